// ### ecgs_pkg.sv
`default_nettype none
package ecgs_pkg;
	// Number of input edges seen before the gate changes state
	localparam int unsigned ECGS_EDGE_COUNT = 4;
	// Width of the edge counters
	localparam int unsigned ECGS_CNT_W = 3;
	// Reset value of the gated output
	localparam logic ECGS_OUT_RST = 1'b0;
	// Reset value of the stopped indication
	localparam logic ECGS_STOPPED_RST = 1'b0;
	// Synchroniser length
	localparam int unsigned ECGS_SYNC_STAGES = 2;

	// Gate states
	typedef enum logic [1:0] {
		ECGS_RUN,
		ECGS_STOPPING,
		ECGS_STOPPED,
		ECGS_STARTING
	} ecgs_state_e;
endpackage : ecgs_pkg
`default_nettype wire

// ### ecgs_sync2.sv
`default_nettype none
module ecgs_sync2 (
	input wire logic ref_clk_in, // System clock
	input wire logic rst_in, // Synchronous reset, active high
	input wire logic async_in, // Level to be synchronised
	output logic sync_out // Synchronised level
);
	logic meta_ff;
	logic sync_ff;

	// Two stages; the first is read by the second only, to contain metastability
	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			meta_ff <= 1'b0;
			sync_ff <= 1'b0;
		end else begin
			meta_ff <= async_in;
			sync_ff <= meta_ff;
		end
	end

	assign sync_out = sync_ff;
endmodule // ecgs_sync2
`default_nettype wire

// ### ecgs_edge_clock_gate_sync.sv
`default_nettype none
module ecgs_edge_clock_gate_sync #(
	parameter int unsigned EDGE_COUNT = ecgs_pkg::ECGS_EDGE_COUNT // Edges before gate change
) (
	input wire logic ref_clk_in, // 100 MHz sampling clock
	input wire logic rst_in, // Synchronous reset, active high
	input wire logic edge_clock_in, // Edge clock to be gated, sampled
	input wire logic stop_in, // Stop request from core logic, high stops
	output logic gated_edge_clock_out, // Gated edge clock
	output logic clock_stopped_out // High while the output is parked low
);
	import ecgs_pkg::*;

	// Counter value at the last counted edge; the counter must be wide enough for EDGE_COUNT
	localparam logic [ECGS_CNT_W-1:0] LAST_EDGE = ECGS_CNT_W'(EDGE_COUNT - 1);

	logic stop_sync;
	logic edge_prev_ff;
	logic stop_edge_ff;
	logic [ECGS_CNT_W-1:0] edge_cnt_ff;
	logic [ECGS_CNT_W-1:0] nxt_edge_cnt;
	ecgs_state_e state_ff;
	ecgs_state_e nxt_state;
	logic gated_ff;
	logic nxt_gated;
	logic stopped_ff;
	wire logic edge_rise;
	wire logic edge_fall;
	wire logic stop_done;
	wire logic start_done;
	wire logic gate_open;
	wire logic nxt_stopped;

	// Stop request comes from another timing domain, so bring it in first
	ecgs_sync2 u_stop_sync (
		.ref_clk_in(ref_clk_in),
		.rst_in(rst_in),
		.async_in(stop_in),
		.sync_out(stop_sync)
	);

	// Edge detection of the sampled edge clock
	assign edge_rise = edge_clock_in & ~edge_prev_ff;
	assign edge_fall = ~edge_clock_in & edge_prev_ff;
	assign stop_done = (state_ff == ECGS_STOPPING) && edge_fall && (edge_cnt_ff == LAST_EDGE);
	assign start_done = (state_ff == ECGS_STARTING) && edge_rise && (edge_cnt_ff == LAST_EDGE);

	// Gate only closes on a falling edge and opens on a rising one, so no runt pulse
	assign gate_open = (state_ff == ECGS_RUN) || (state_ff == ECGS_STOPPING)
		|| (start_done && !stop_edge_ff);
	// A high phase passes only from its start, so a gate opened mid phase stays low
	assign nxt_gated = gate_open & edge_clock_in & ~stop_done
		& (gated_ff | edge_rise);

	// Parked covers the restart count too, so users see one flag until clocks flow
	function automatic logic is_parked(input ecgs_state_e s);
		return (s == ECGS_STOPPED) || (s == ECGS_STARTING);
	endfunction
	assign nxt_stopped = is_parked(nxt_state);

	// Next state and edge counter
	// Input phases shorter than one sampling cycle can be missed; keep the edge clock slow
	always_comb begin
		nxt_state = state_ff;
		nxt_edge_cnt = edge_cnt_ff;
		case (state_ff)
			ECGS_RUN: begin
				if (stop_edge_ff) begin
					nxt_state = ECGS_STOPPING;
					nxt_edge_cnt = '0;
				end
			end
			ECGS_STOPPING: begin
				// A release before the fourth fall simply leaves the clock running
				if (!stop_edge_ff) begin
					nxt_state = ECGS_RUN;
				end else if (stop_done) begin
					nxt_state = ECGS_STOPPED;
				end else if (edge_fall) begin
					nxt_edge_cnt = edge_cnt_ff + 1'b1;
				end
			end
			ECGS_STOPPED: begin
				if (!stop_edge_ff) begin
					nxt_state = ECGS_STARTING;
					nxt_edge_cnt = '0;
				end
			end
			ECGS_STARTING: begin
				// A new stop during restart parks the output again without a pulse
				if (stop_edge_ff) begin
					nxt_state = ECGS_STOPPED;
				end else if (start_done) begin
					nxt_state = ECGS_RUN;
				end else if (edge_rise) begin
					nxt_edge_cnt = edge_cnt_ff + 1'b1;
				end
			end
			default: begin
				nxt_state = ECGS_RUN;
			end
		endcase
	end

	// Edge history follows the pin even in reset, so release never shows a false edge
	always_ff @(posedge ref_clk_in) begin
		edge_prev_ff <= edge_clock_in;
	end

	// Stop is taken into the edge clock's own timing on its rising edges
	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			stop_edge_ff <= 1'b0;
		end else if (edge_rise) begin
			stop_edge_ff <= stop_sync;
		end
	end

	// State, counter and registered outputs
	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			state_ff <= ECGS_RUN;
			edge_cnt_ff <= '0;
			gated_ff <= ECGS_OUT_RST;
			stopped_ff <= ECGS_STOPPED_RST;
		end else begin
			state_ff <= nxt_state;
			edge_cnt_ff <= nxt_edge_cnt;
			gated_ff <= nxt_gated;
			stopped_ff <= nxt_stopped;
		end
	end

	assign gated_edge_clock_out = gated_ff;
	assign clock_stopped_out = stopped_ff;

	// Output rises only with the input, never mid high phase
	chk_rise_follows_in: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		$rose(gated_ff) |-> $past(edge_clock_in) && !$past(edge_prev_ff))
		else $error("gated output rose without an input rising edge");

	// Output falls only with the input, so no high phase is cut short
	chk_fall_follows_in: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		$fell(gated_ff) |-> !$past(edge_clock_in))
		else $error("gated output fell while input was high");

	// Resynchronised stop moves only on an input rising edge
	chk_stop_resync: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		$changed(stop_edge_ff) |-> $past(edge_rise))
		else $error("stop changed outside an edge clock rising edge");

	// Parking happens only on the fourth falling edge
	chk_stop_fourth: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		(state_ff == ECGS_STOPPED) && $past(state_ff == ECGS_STOPPING)
		|-> $past(edge_fall) && $past(edge_cnt_ff) == LAST_EDGE && !gated_ff)
		else $error("clock parked at the wrong falling edge");

	// Restart happens only on the fourth rising edge, with the output high
	chk_start_fourth: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		(state_ff == ECGS_RUN) && $past(state_ff == ECGS_STARTING)
		|-> $past(edge_rise) && $past(edge_cnt_ff) == LAST_EDGE && gated_ff)
		else $error("clock restarted at the wrong rising edge");

	// While parked and still stopped, output stays low and state holds
	chk_hold_low: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		(state_ff == ECGS_STOPPED) && stop_edge_ff |=> (state_ff == ECGS_STOPPED) && !gated_ff)
		else $error("output left the parked state while stop held");

	// While parked the output is low whatever stop does
	chk_park_low: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		(state_ff == ECGS_STOPPED) |-> !gated_ff)
		else $error("gated output high while parked");

	// Parked state is always reported on the status output
	chk_flag_parked: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		(state_ff == ECGS_STOPPED) |-> stopped_ff)
		else $error("status low while the clock is parked");

	// No output pulse is let through while restart edges are still counted
	chk_restart_quiet: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		(state_ff == ECGS_STARTING) |-> !gated_ff)
		else $error("gated output high before restart completed");

	// Restart counting begins from zero
	chk_start_entry: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		(state_ff == ECGS_STARTING) && $past(state_ff == ECGS_STOPPED) |-> edge_cnt_ff == '0)
		else $error("restart count did not begin at zero");

	// Stop counting begins from zero, one cycle after the latched stop
	chk_stop_entry: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		(state_ff == ECGS_STOPPING) && $past(state_ff == ECGS_RUN)
		|-> edge_cnt_ff == '0 && $past(stop_edge_ff))
		else $error("stop count did not begin at zero");

	// A stop released before the last fall leaves the clock running
	chk_abort_runs: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		(state_ff == ECGS_STOPPING) && !stop_edge_ff |=> state_ff == ECGS_RUN)
		else $error("released stop did not return to running");

	// A stop that returns during restart parks again without a pulse
	chk_restop_park: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		(state_ff == ECGS_STARTING) && stop_edge_ff
		|=> (state_ff == ECGS_STOPPED) && !gated_ff)
		else $error("stop during restart let a pulse through");

	// The edge counter never passes the last counted edge
	chk_count_bound: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		edge_cnt_ff <= LAST_EDGE)
		else $error("edge counter ran past the last edge");

	// Once running and high, the output copies the input one cycle later
	chk_run_follows: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		(state_ff == ECGS_RUN) && gated_ff |=> gated_ff == $past(edge_clock_in))
		else $error("running output did not follow the input");
endmodule // ecgs_edge_clock_gate_sync
`default_nettype wire

// ### ecgs_core_model.sv
`default_nettype none
// Core side: slow edge clock (4 high, 4 low) and the stop level
module ecgs_core_model (
	input wire logic ref_clk_in, // Sampling clock
	input wire logic stop_req_in, // Stop wanted by the bench
	output logic edge_clock_out, // Edge clock to gate
	output logic stop_out // Stop level to the gate
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [2:0] phase = 3'h0;
	// Moves 1 ns after the edge so the gate never samples a changing input
	initial begin
		edge_clock_out = 1'b0;
		stop_out = 1'b0;
		forever begin
			@(posedge ref_clk_in);
			#1;
			phase = phase + 3'h1;
			edge_clock_out = phase[2];
			stop_out = stop_req_in; // Held for as long as asked
		end
	end
endmodule // ecgs_core_model
`default_nettype wire

// ### tb_top.sv
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import ecgs_pkg::*;
	logic ref_clk_in, rst_in, stop_req, edge_clk, stop_lvl, gated, stopped;
	logic prev_g = 1'b0;
	logic prev_e = 1'b0;
	int n_mismatch, total_checks, cyc, run, n_fall, n_rise, n_grise, seen;
	ecgs_core_model partner (.ref_clk_in(ref_clk_in), .stop_req_in(stop_req),
		.edge_clock_out(edge_clk), .stop_out(stop_lvl));
	ecgs_edge_clock_gate_sync DUT (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
		.edge_clock_in(edge_clk), .stop_in(stop_lvl), .gated_edge_clock_out(gated),
		.clock_stopped_out(stopped));
	task automatic check(input string what, input int exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("wrong value %s expected %0d seen %0d", what, exp, got);
		end
	endtask
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk_in);
		#1;
	endtask
	// Mid-cycle monitor; a short high pulse would mean a runt on the output
	always @(negedge ref_clk_in) begin
		cyc++;
		if (prev_e && !edge_clk) n_fall++;
		if (!prev_e && edge_clk) n_rise++;
		if (!prev_g && gated) n_grise++;
		if (prev_g && !gated) check("pulse width", 4, run);
		run = gated ? run + 1 : 0;
		prev_g = gated;
		prev_e = edge_clk;
		if (cyc == 2000) begin
			n_mismatch++;
			print_verdict();
		end
	end
	task automatic test_stop();
		@(negedge edge_clk);
		stop_req = 1'b1;
		n_fall = 0;
		for (int i = 0; i < 100 && stopped !== 1'b1; i++) tick(1);
		// The aligning fall is counted too, the gate does not see it
		check("falls to stop", ECGS_EDGE_COUNT + 1, n_fall);
		n_grise = 0;
		tick(40);
		check("rises while parked", 0, n_grise);
		$display("test stop done");
	endtask
	task automatic test_start();
		@(negedge edge_clk);
		stop_req = 1'b0;
		n_rise = 0;
		for (int i = 0; i < 100 && gated !== 1'b1; i++) tick(1);
		check("rises to restart", ECGS_EDGE_COUNT + 1, n_rise);
		tick(2);
		check("stopped flag", 0, stopped);
		$display("test start done");
	endtask
	// Release after one counted fall: the clock must never park
	task automatic test_abort();
		@(negedge edge_clk);
		stop_req = 1'b1;
		n_fall = 0;
		for (int i = 0; i < 40 && n_fall < 2; i++) tick(1);
		stop_req = 1'b0;
		seen = 0;
		n_grise = 0;
		for (int i = 0; i < 80; i++) begin
			tick(1);
			if (stopped !== 1'b0) seen = 1;
		end
		check("parked after early release", 0, seen);
		check("rises after early release", 10, n_grise);
		$display("test abort done");
	endtask
	// Stop again three rises into a restart: the output must stay parked
	task automatic test_restop();
		@(negedge edge_clk);
		stop_req = 1'b0;
		n_grise = 0;
		tick(20);
		stop_req = 1'b1;
		tick(40);
		check("rises on re-stop", 0, n_grise);
		check("stopped on re-stop", 1, stopped);
		$display("test restop done");
	endtask
	// Reset in mid-run while parked: outputs clear and the clock passes again
	task automatic test_reset();
		@(negedge edge_clk);
		rst_in = 1'b1;
		stop_req = 1'b0;
		tick(4);
		check("gated in reset", 0, gated);
		check("stopped in reset", 0, stopped);
		rst_in = 1'b0;
		n_grise = 0;
		tick(40);
		check("rises after reset", 5, n_grise);
		check("stopped after reset", 0, stopped);
		$display("test reset done");
	endtask
	initial begin
		ref_clk_in = 1'b0;
		forever #5 ref_clk_in = ~ref_clk_in;
	end
	// Reset for 4 cycles, then the scenarios back to back
	initial begin
		rst_in = 1'b1;
		stop_req = 1'b0;
		tick(4);
		rst_in = 1'b0;
		n_grise = 0;
		tick(40);
		check("rises while open", 5, n_grise);
		test_stop();
		test_start();
		test_abort();
		test_stop();
		test_restop();
		test_start();
		test_stop();
		test_reset();
		print_verdict();
	end
endmodule // tb_top
`default_nettype wire
